// [ati_link_asserts.sv]
/*
 * Link checker for the rule-table access path.
 * Assumes one clock and a sync active-high reset shared by both ends.
 */
`timescale 1ns/1ps
module ati_link_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    import ati_pkg::*;
    logic [7:0] sel;
    logic [7:0] ofs;
    logic [7:0] since;
    logic rd_data;
    logic rule_ok;
    logic launch;
    assign rd_data = ack && !we && addr == ADDR_DATA;
    // Port nibble 1 to 5 is valid, as in the switch end
    assign rule_ok = sel[7:SEL_FUNC_LSB] == FUNC_RULE && sel[3:0] >= 4'h1 && sel[3:0] <= 4'h5;
    assign launch = ack && we && addr == ADDR_DATA && rule_ok && !sel[SEL_READ_BIT]
        && ofs == OFS_CONTROL && wdata[CTL_DIR];
    always_ff @(posedge clk_i) begin
        if (rst_i) sel <= SEL_RESET;
        else if (ack && we && addr == ADDR_SELECT) sel <= wdata;
    end
    // Reads always step the offset; writes only when they land
    always_ff @(posedge clk_i) begin
        if (rst_i) ofs <= OFS_RESET;
        else if (ack && we && addr == ADDR_OFFSET) ofs <= wdata;
        else if (ack && addr == ADDR_DATA && (!we || (rule_ok && !sel[SEL_READ_BIT])))
            ofs <= ofs + 8'h01;
    end
    // Saturates so the idle state reads as long done
    always_ff @(posedge clk_i) begin
        if (rst_i) since <= 8'hff;
        else if (launch) since <= 8'h00;
        else if (since != 8'hff) since <= since + 8'h01;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        req && !ack;
    endsequence
    sequence rd_ctl_s;
        rd_data && rule_ok && ofs == OFS_CONTROL;
    endsequence
    ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    ack_latency_a: assert property (take_s |=> ack) else $error("ack not one cycle after take");
    req_hold_a: assert property (take_s |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    req_release_a: assert property (ack |=> !req) else $error("request kept after ack");
    rdata_hold_a: assert property (!$stable(rdata) |-> ack && !we) else $error("read data moved");
    bad_select_a: assert property (rd_data && !rule_ok |-> rdata == 8'h00)
        else $error("data read under foreign select not zero");
    ctl_reserved_a: assert property (rd_ctl_s |-> !rdata[7]) else $error("control bit 7 set");
    opt_reserved_a: assert property (rd_data && rule_ok && ofs == OFS_OPTION |-> rdata[7:1] == 7'h00)
        else $error("option reserved bits set");
    upper_reserved_a: assert property (rd_data && rule_ok && ofs == OFS_SEL_UPPER
        |-> rdata[7:6] == 2'h0) else $error("upper select reserved bits set");
    wr_busy_a: assert property (rd_ctl_s and since < 8'd14 |-> !rdata[CTL_WR_DONE])
        else $error("write flag set too soon");
    wr_done_a: assert property (rd_ctl_s and since > 8'd13 |-> rdata[CTL_WR_DONE])
        else $error("write flag not set after transfer");
endmodule : ati_link_asserts

// [ati_link_if.sv]
/*
 * Register-port link between the host controller and the switch
 * rule-table logic. Assumes both ends share clk_i and rst_i.
 */
`timescale 1ns/1ps
interface ati_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport device (input req, input we, input addr, input wdata, output rdata, output ack);
    modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : ati_link_if

// [ati_pkg.sv]
/*
 * Shared constants for the rule-table indirect access link:
 * register port addresses, per-port offsets, field positions, resets.
 * Assumes both ends and the host's Wishbone map import it.
 */
package ati_pkg;
    localparam int PORTS = 4;
    localparam int ENTRIES = 16;
    localparam int ENTRY_BYTES = 14;
    // Switch register port addresses
    localparam logic [7:0] ADDR_SELECT = 8'h6e;
    localparam logic [7:0] ADDR_OFFSET = 8'h6f;
    localparam logic [7:0] ADDR_DATA = 8'ha0;
    // Select byte fields
    localparam logic [2:0] FUNC_RULE = 3'b010;
    localparam int SEL_FUNC_LSB = 5;
    localparam int SEL_READ_BIT = 4;
    // Per-port indirect offsets
    localparam logic [7:0] OFS_LAST_BYTE = 8'h0d;
    localparam logic [7:0] OFS_SEL_UPPER = 8'h10;
    localparam logic [7:0] OFS_SEL_LOWER = 8'h11;
    localparam logic [7:0] OFS_CONTROL = 8'h12;
    localparam logic [7:0] OFS_OPTION = 8'h13;
    // Access control byte fields, upper select width and reset values
    localparam int CTL_WR_DONE = 6;
    localparam int CTL_RD_DONE = 5;
    localparam int CTL_DIR = 4;
    localparam int SEL_UPPER_BITS = 6;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h00;
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [13:0] BYTE_SEL_RESET = 14'h0000;
    // Host Wishbone map
    localparam logic [7:0] WB_CMD = 8'h00;
    localparam logic [7:0] WB_STATUS = 8'h04;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WE_BIT = 16;
    localparam int CMD_GO_BIT = 31;
    localparam int STAT_RDATA_LSB = 8;
endpackage : ati_pkg

// [ati_rule_dev.sv]
/*
 * Switch end: select/offset/data indirect registers, per-port holding
 * buffers, byte selects, control bytes and the 4x16x14 rule table with
 * its byte-serial transfer engine.
 * Assumes the host holds req until ack and same clock as the link.
 */
// Our own choice: the Wishbone register port.
// Functional notes
// R1 - Bit 6 shows write done, resets 1
// R2 - Bit 5 shows read done, resets 1
// R3 - Bit 4 picks write or read direction
// R4 - Bits 3:0 pick entry 0 to 15
// R5 - Option bit 0 sets single-entry ring miss
// R6 - Write direction copies buffer into entry
// R7 - Only selected bytes are written
// R8 - Read bytes appear at offsets 0x00-0x0D
// R9 - Host polls bit 6 before new write
// R10 - Host polls bit 5 before fetching bytes
// R11 - Select bits 7:5 = 010, low nibble port
// R12 - Host uses 0x4n writes, 0x5n reads
// R13 - Offset picks location behind data byte
// R14 - Selects 0x3F/0xFF cover all fourteen bytes
// R15 - Host loads bytes, selects, then control
// R16 - Consecutive data accesses work as burst
// R17 - Select bit 13 is byte 0x00
// R18 - Flag clears at launch, sets when done
// R19 - Reserved control bits read zero
`timescale 1ns/1ps
module ati_rule_dev (
    input wire logic clk_i,
    input wire logic rst_i,
    ati_link_if.device link,
    output logic [ati_pkg::PORTS-1:0] ring_filter_single_entry_miss_o,
    output logic xfer_busy_o
);
    import ati_pkg::*;

    logic [7:0] sel;
    logic [7:0] ofs;
    logic [7:0] hold_buf [PORTS][ENTRY_BYTES];
    logic [7:0] rule_tab [PORTS][ENTRIES][ENTRY_BYTES];
    logic [13:0] entry_byte_select [PORTS];
    logic [PORTS-1:0] dir_write;
    logic [3:0] rule_entry_index [PORTS];
    logic [PORTS-1:0] wr_done;
    logic [PORTS-1:0] rd_done;
    logic [PORTS-1:0] ring_filter_single_entry_miss;

    logic busy;
    logic [1:0] eng_port;
    logic eng_write;
    logic [3:0] eng_entry;
    logic [3:0] eng_k;

    logic take;
    logic port_ok;
    logic [1:0] pidx;
    logic rule_sel;
    logic wr_loc;
    logic rd_loc;
    logic launch;
    logic [7:0] loc_val;
    logic [7:0] next_rdata;

    assign take = link.req && !link.ack;

    // Port nibble 4 and 5 both reach the fourth port
    always_comb begin
        port_ok = 1'b1;
        case (sel[3:0])
            4'h1: pidx = 2'd0;
            4'h2: pidx = 2'd1;
            4'h3: pidx = 2'd2;
            4'h4, 4'h5: pidx = 2'd3;
            default: begin
                pidx = 2'd0;
                port_ok = 1'b0;
            end
        endcase
    end

    assign rule_sel = (sel[7:SEL_FUNC_LSB] == FUNC_RULE) && port_ok; // R11
    // Writes only land while the select names the write function
    assign wr_loc = take && link.we && link.addr == ADDR_DATA && rule_sel
        && !sel[SEL_READ_BIT]; // R12
    assign rd_loc = take && !link.we && link.addr == ADDR_DATA;
    // A launch while the engine runs is dropped whole
    assign launch = wr_loc && ofs == OFS_CONTROL && !busy;

    always_comb begin
        loc_val = 8'h00;
        if (rule_sel) begin
            if (ofs <= OFS_LAST_BYTE) begin
                loc_val = hold_buf[pidx][ofs[3:0]]; // R8
            end else begin
                case (ofs)
                    OFS_SEL_UPPER: loc_val = {2'b00, entry_byte_select[pidx][13:8]};
                    OFS_SEL_LOWER: loc_val = entry_byte_select[pidx][7:0];
                    OFS_CONTROL: loc_val = {1'b0, wr_done[pidx], rd_done[pidx],
                        dir_write[pidx], rule_entry_index[pidx]}; // R1 R2 R19
                    OFS_OPTION: loc_val = {7'h00, ring_filter_single_entry_miss[pidx]}; // R19
                    default: loc_val = 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        case (link.addr)
            ADDR_SELECT: next_rdata = sel;
            ADDR_OFFSET: next_rdata = ofs;
            ADDR_DATA: next_rdata = loc_val;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.ack <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack <= take;
            if (take && !link.we) begin
                link.rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel <= SEL_RESET;
        end else if (take && link.we && link.addr == ADDR_SELECT) begin
            sel <= link.wdata;
        end
    end

    // Offset steps after each data read and each landed data write so bursts walk the map
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ofs <= OFS_RESET;
        end else if (take && link.we && link.addr == ADDR_OFFSET) begin
            ofs <= link.wdata; // R13
        end else if (wr_loc || rd_loc) begin
            ofs <= ofs + 8'h01; // R16
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PORTS; p++) begin
                entry_byte_select[p] <= BYTE_SEL_RESET;
                ring_filter_single_entry_miss[p] <= 1'b0;
            end
        end else if (wr_loc) begin
            case (ofs)
                OFS_SEL_UPPER: entry_byte_select[pidx][13:8] <=
                    link.wdata[SEL_UPPER_BITS-1:0]; // R14 R19
                OFS_SEL_LOWER: entry_byte_select[pidx][7:0] <= link.wdata; // R14
                OFS_OPTION: ring_filter_single_entry_miss[pidx] <= link.wdata[0]; // R5
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PORTS; p++) begin
                dir_write[p] <= 1'b0;
                rule_entry_index[p] <= INDEX_RESET;
            end
        end else if (launch) begin
            dir_write[pidx] <= link.wdata[CTL_DIR]; // R3
            rule_entry_index[pidx] <= link.wdata[3:0]; // R4
        end
    end

    // Launch never meets a done edge: launches wait for idle engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_done <= '1; // R1
            rd_done <= '1; // R2
        end else if (launch) begin
            if (link.wdata[CTL_DIR]) begin
                wr_done[pidx] <= 1'b0; // R18
            end else begin
                rd_done[pidx] <= 1'b0; // R18
            end
        end else if (busy && eng_k == 4'(ENTRY_BYTES - 1)) begin
            if (eng_write) begin
                wr_done[eng_port] <= 1'b1; // R18
            end else begin
                rd_done[eng_port] <= 1'b1; // R18
            end
        end
    end

    // One byte per cycle, fourteen cycles per transfer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            eng_port <= 2'd0;
            eng_write <= 1'b0;
            eng_entry <= 4'h0;
            eng_k <= 4'h0;
        end else if (launch) begin
            busy <= 1'b1;
            eng_port <= pidx;
            eng_write <= link.wdata[CTL_DIR]; // R6
            eng_entry <= link.wdata[3:0];
            eng_k <= 4'h0;
        end else if (busy) begin
            if (eng_k == 4'(ENTRY_BYTES - 1)) begin
                busy <= 1'b0;
            end
            eng_k <= eng_k + 4'h1;
        end
    end

    logic byte_on;
    assign byte_on = busy && entry_byte_select[eng_port][4'(ENTRY_BYTES - 1) - eng_k]; // R17

    always_ff @(posedge clk_i) begin
        if (byte_on && eng_write) begin
            rule_tab[eng_port][eng_entry][eng_k] <= hold_buf[eng_port][eng_k]; // R6 R7
        end
    end

    // Engine fill wins over a host write to the same byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PORTS; p++) begin
                for (int b = 0; b < ENTRY_BYTES; b++) begin
                    hold_buf[p][b] <= 8'h00;
                end
            end
        end else begin
            if (wr_loc && ofs <= OFS_LAST_BYTE) begin
                hold_buf[pidx][ofs[3:0]] <= link.wdata; // R15
            end
            if (byte_on && !eng_write) begin
                hold_buf[eng_port][eng_k] <= rule_tab[eng_port][eng_entry][eng_k]; // R8
            end
        end
    end

    assign ring_filter_single_entry_miss_o = ring_filter_single_entry_miss; // R5
    assign xfer_busy_o = busy;
endmodule : ati_rule_dev

// [ati_rule_host.sv]
/*
 * Host end: a classic Wishbone slave holding one command register and
 * one status register; each command becomes one byte access on the
 * link. Software sequences select, offset and data bytes and polls.
 * Assumes the device answers every request with a one-cycle ack.
 */
`timescale 1ns/1ps
module ati_rule_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ati_link_if.host link
);
    import ati_pkg::*;

    typedef enum logic [1:0] {
        ATI_IDLE = 2'b01,
        ATI_WAIT = 2'b10
    } ati_state_t;

    ati_state_t state;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic cmd_we;
    logic [7:0] last_rdata;
    logic wb_take;
    logic go;

    assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A go while busy is ignored; software polls the busy bit first
    assign go = wb_take && wb_we_i && wb_adr_i == WB_CMD && wb_sel_i[3]
        && wb_dat_i[CMD_GO_BIT] && state == ATI_IDLE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_take;
            if (wb_take && !wb_we_i) begin
                case (wb_adr_i)
                    WB_CMD: wb_dat_o <= {15'h0000, cmd_we, cmd_wdata, cmd_addr};
                    WB_STATUS: wb_dat_o <= {16'h0000, last_rdata, 7'h00,
                        state == ATI_WAIT};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command fields honour byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_addr <= 8'h00;
            cmd_wdata <= 8'h00;
            cmd_we <= 1'b0;
        end else if (wb_take && wb_we_i && wb_adr_i == WB_CMD && state == ATI_IDLE) begin
            if (wb_sel_i[0]) begin
                cmd_addr <= wb_dat_i[7:0]; // R11 R12 R13
            end
            if (wb_sel_i[1]) begin
                cmd_wdata <= wb_dat_i[CMD_WDATA_LSB +: 8]; // R14 R15
            end
            if (wb_sel_i[2]) begin
                cmd_we <= wb_dat_i[CMD_WE_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ATI_IDLE;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.addr <= 8'h00;
            link.wdata <= 8'h00;
            last_rdata <= 8'h00;
        end else begin
            case (state)
                ATI_IDLE: begin
                    if (go) begin
                        state <= ATI_WAIT;
                        link.req <= 1'b1;
                        link.we <= wb_sel_i[2] ? wb_dat_i[CMD_WE_BIT] : cmd_we;
                        link.addr <= wb_sel_i[0] ? wb_dat_i[7:0] : cmd_addr;
                        link.wdata <= wb_sel_i[1] ? wb_dat_i[CMD_WDATA_LSB +: 8] : cmd_wdata;
                    end
                end
                ATI_WAIT: begin
                    if (link.ack) begin
                        state <= ATI_IDLE;
                        link.req <= 1'b0;
                        if (!link.we) begin
                            last_rdata <= link.rdata; // R9 R10 R16
                        end
                    end
                end
                default: begin
                    state <= ATI_IDLE;
                    link.req <= 1'b0;
                end
            endcase
        end
    end
endmodule : ati_rule_host

// [testbench.sv]
/*
 * Bench driving the host end over Wishbone, both ends joined by the link.
 * Assumes the host acks each Wishbone cycle and reports busy in STATUS.
 */
`timescale 1ns/1ps
module testbench;
    import ati_pkg::*;
    logic clk_i;
    logic rst_i;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0] wb_sel;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat, wb_dat_o;
    logic [PORTS-1:0] miss;
    logic busy;
    logic [15:0] lfsr;
    logic [31:0] r;
    logic [7:0] q;
    int num_errors, tests_run, cycles, e;
    int stage[14];
    int tab[14];
    logic [3:0] e_nib[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
    ati_link_if ati_link_if_inst ();
    ati_rule_dev ati_rule_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(ati_link_if_inst),
        .ring_filter_single_entry_miss_o(miss), .xfer_busy_o(busy));
    ati_rule_host ati_rule_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .link(ati_link_if_inst));
    ati_link_asserts ati_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
        .req(ati_link_if_inst.req), .we(ati_link_if_inst.we), .addr(ati_link_if_inst.addr),
        .wdata(ati_link_if_inst.wdata), .rdata(ati_link_if_inst.rdata),
        .ack(ati_link_if_inst.ack));
    function automatic int rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return int'(lfsr[7:0]);
    endfunction : rnd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] dq);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hf;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        dq = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] dq);
        logic [31:0] s;
        wb(1'b1, WB_CMD, {1'b1, 14'h0000, w, d, a}, s);
        do wb(1'b0, WB_STATUS, 32'h0, s); while (s[0] !== 1'b0);
        dq = s[15:8];
    endtask : op
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dq;
        op(1'b1, a, d, dq);
    endtask : wr
    task automatic rd(output logic [7:0] dq);
        op(1'b0, ADDR_DATA, 8'h00, dq);
    endtask : rd
    // Selects then control in one burst, then polls both flags
    task automatic xfer(input logic [3:0] nib, input logic [7:0] up, input logic [7:0] lo,
        input logic [7:0] ctl);
        logic [7:0] dq;
        wr(ADDR_SELECT, {4'h4, nib});
        wr(ADDR_OFFSET, OFS_SEL_UPPER);
        wr(ADDR_DATA, up);
        wr(ADDR_DATA, lo);
        wr(ADDR_DATA, ctl);
        chk("busy", 32'h1, {31'h0, busy});
        wr(ADDR_OFFSET, OFS_CONTROL);
        rd(dq);
        chk("flag clear", {30'h0, (ctl[4] ? 2'b01 : 2'b10)}, {30'h0, dq[6:5]});
        while (dq[6:5] !== 2'b11) begin
            wr(ADDR_OFFSET, OFS_CONTROL);
            rd(dq);
        end
        chk("busy idle", 32'h0, {31'h0, busy});
        chk("control", {24'h0, 3'b011, ctl[4:0]}, {24'h0, dq});
    endtask : xfer
    task automatic load(input logic [3:0] nib);
        wr(ADDR_SELECT, {4'h4, nib});
        wr(ADDR_OFFSET, 8'h00);
        for (int k = 0; k < ENTRY_BYTES; k++) wr(ADDR_DATA, stage[k][7:0]);
    endtask : load
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} = '0;
        rst_i = 1'b1;
        lfsr = 16'he36f;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(ADDR_SELECT, 8'h51);
        wr(ADDR_OFFSET, OFS_CONTROL);
        rd(q);
        chk("control reset", 32'h60, {24'h0, q});
        rd(q);
        chk("option reset", 32'h0, {24'h0, q});
        $display("test reset_values done");
        foreach (e_nib[i]) begin
            e = (i == 3) ? 15 : rnd() % ENTRIES;
            for (int k = 0; k < ENTRY_BYTES; k++) stage[k] = rnd();
            tab = stage;
            load(e_nib[i]);
            xfer(e_nib[i], 8'h3f, 8'hff, {4'h1, 4'(e)});
            for (int k = 0; k < ENTRY_BYTES; k++) begin
                stage[k] = rnd();
                if (k % 2 == 1) tab[k] = stage[k];
            end
            load(e_nib[i]);
            xfer(e_nib[i], 8'h15, 8'h55, {4'h1, 4'(e)});
            xfer(e_nib[i], 8'h3f, 8'hff, {4'h0, 4'(e)});
            wr(ADDR_SELECT, {4'h5, e_nib[i]});
            wr(ADDR_OFFSET, 8'h00);
            for (int k = 0; k < ENTRY_BYTES; k++) begin
                rd(q);
                chk("entry byte", tab[k], {24'h0, q});
            end
            $display("test entry port %0d done", i);
        end
        wr(ADDR_SELECT, 8'h42);
        wr(ADDR_OFFSET, OFS_OPTION);
        wr(ADDR_DATA, 8'hff);
        wr(ADDR_OFFSET, OFS_OPTION);
        rd(q);
        chk("option", 32'h01, {24'h0, q});
        chk("ring miss", 32'h2, {28'h0, miss});
        wr(ADDR_OFFSET, OFS_SEL_UPPER);
        wr(ADDR_DATA, 8'hff);
        wr(ADDR_OFFSET, OFS_SEL_UPPER);
        rd(q);
        chk("select upper", 32'h3f, {24'h0, q});
        rd(q);
        chk("select lower", 32'hff, {24'h0, q});
        wr(ADDR_SELECT, 8'h61);
        wr(ADDR_OFFSET, OFS_CONTROL);
        rd(q);
        chk("foreign select", 32'h0, {24'h0, q});
        wb(1'b0, 8'h08, 32'h0, r);
        chk("unmapped", 32'h0, r);
        $display("test option_select done");
        wrap_up();
    end
endmodule : testbench
